// ==== asm_pkg.sv ====
// package for the audio slot channel mapper: register map, field layout,
// reset values and frame format codes. no surroundings assumed.
package asm_pkg;
   // register offsets on page 0
   localparam logic [7:0] CHAN_B_CFG_ADDR = 8'h0c;
   localparam logic [7:0] CHAN_C_CFG_ADDR = 8'h0d;
   localparam logic [7:0] CHAN_D_CFG_ADDR = 8'h0e;
   localparam logic [7:0] PAGE_ZERO       = 8'h00;
   // field layout
   localparam int RSVD_BIT     = 7;
   localparam int LINE_SEL_BIT = 6;
   localparam int SLOT_MSB     = 5;
   localparam int SLOT_W       = 6;
   localparam logic [5:0] HALF_SPLIT = 6'h20;
   // reset values
   localparam logic [7:0] CHAN_B_RESET = 8'h01;
   localparam logic [7:0] CHAN_C_RESET = 8'h02;
   localparam logic [7:0] CHAN_D_RESET = 8'h03;
   localparam logic [7:0] CFG_WMASK    = 8'h7f;
   // frame formats
   typedef enum logic [1:0] {
      FMT_TDM  = 2'h0,
      FMT_I2S  = 2'h1,
      FMT_LJ   = 2'h2
   } asm_format_type;
   localparam int SAMPLE_W   = 32;
   localparam int FIFO_DEPTH = 8;
endpackage

// ==== asm_fifo.sv ====
// small synchronous fifo with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module asm_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("asm_fifo: depth must be a power of two");
   end

   typedef struct packed {
      logic [AW:0]      wr;
      logic [AW:0]      rd;
      logic [WIDTH-1:0] dout;
      logic             dvalid;
   } asm_fifo_state_type;

   asm_fifo_state_type       s_q, s_d;
   logic [WIDTH-1:0]         mem_q [DEPTH];
   logic                     full, empty, push, pop;

   assign full      = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
   assign empty     = (s_q.wr == s_q.rd);
   assign in_ready  = !full;
   assign push      = in_valid && !full;
   // output register reloads when empty or being taken
   assign pop       = !empty && (!s_q.dvalid || out_ready);
   assign out_valid = s_q.dvalid;
   assign out_data  = s_q.dout;

   always_comb begin
      s_d = s_q;
      if (push) s_d.wr = s_q.wr + 1'b1;
      if (out_ready && s_q.dvalid) s_d.dvalid = 1'b0;
      if (pop) begin
         s_d.rd     = s_q.rd + 1'b1;
         s_d.dout   = mem_q[s_q.rd[AW-1:0]];
         s_d.dvalid = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) s_q <= '0;
      else          s_q <= s_d;
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[s_q.wr[AW-1:0]] <= in_data;
   end

   a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!reset_n)
      full |-> ##1 (s_q.wr == $past(s_q.wr)))
      else $error("fifo written while full");
endmodule

// ==== asm_slot_mapper.sv ====
// audio slot channel mapper: three channel slot-configuration registers and
// the serializer that places channel b, c, d samples into frame slots.
// assumes bit clock and frame sync arrive as pins; samples come from same-clock logic.
//
// Summary of operation
// - config registers at page 0 offsets 0c, 0d, 0e
// - line select clear: primary serial out
// - line select set: secondary general pin
// - slot 0..31: tdm slot or left half
// - slot 32..63: tdm slot or right half
// - channel b resets to slot 1, primary
// - channel c resets to slot 2, primary
// - channel d resets to slot 3, primary
`timescale 1ns/10ps
module asm_slot_mapper #(
   parameter int WORD_W = asm_pkg::SAMPLE_W,
   parameter int DEPTH  = asm_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // register port
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_page,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   // frame format
   input  wire logic [1:0]        frame_format,
   // sample stream: one word each for channel b, c, d in that order
   input  wire logic              smp_valid,
   output logic                   smp_ready,
   input  wire logic [WORD_W-1:0] smp_data,
   // serial pins
   input  wire logic              bit_clk_pin,
   input  wire logic              frame_sync_pin,
   output logic                   primary_serial_out,
   output logic                   primary_serial_oe,
   output logic                   general_pin_one,
   output logic                   general_pin_one_oe
);
   initial begin
      if (WORD_W < 8 || WORD_W > 32) $error("asm_slot_mapper: word width 8..32 only");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]        bclk_sync;
      logic [2:0]        fs_sync;
      logic [7:0]        cfg_b;
      logic [7:0]        cfg_c;
      logic [7:0]        cfg_d;
      logic [7:0]        rdata;
      logic [5:0]        slot;
      logic [5:0]        bitn;
      logic [WORD_W-1:0] word_b;
      logic [WORD_W-1:0] word_c;
      logic [WORD_W-1:0] word_d;
      logic [WORD_W-1:0] out_b;
      logic [WORD_W-1:0] out_c;
      logic [WORD_W-1:0] out_d;
      logic [1:0]        load_idx;
      logic              prim;
      logic              prim_oe;
      logic              sec;
      logic              sec_oe;
   } asm_state_type;

   asm_state_type      s_q, s_d;
   logic               f_valid, f_ready;
   logic [WORD_W-1:0]  f_data;
   logic               bclk_fall, fs_rise, fs_level;
   logic [5:0]         eff_slot [3];
   logic [2:0]         hit;
   logic [2:0]         line_sel;
   logic [WORD_W-1:0]  words [3];
   logic [7:0]         cfgs [3];

   asm_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (smp_valid),
      .in_ready  (smp_ready),
      .in_data   (smp_data),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // ------------------------------------------------------------
   // slot matching per channel
   // ------------------------------------------------------------
   assign bclk_fall = s_q.bclk_sync[2] && !s_q.bclk_sync[1];
   assign fs_level  = s_q.fs_sync[1];
   assign fs_rise   = fs_level && !s_q.fs_sync[2];
   assign cfgs[0]   = s_q.cfg_b;
   assign cfgs[1]   = s_q.cfg_c;
   assign cfgs[2]   = s_q.cfg_d;
   // the frame sends the set latched at its start, so refills never touch bits in flight
   assign words[0]  = s_q.out_b;
   assign words[1]  = s_q.out_c;
   assign words[2]  = s_q.out_d;

   for (genvar i = 0; i < 3; i++) begin : g_chan
      always_comb begin
         // two-channel formats: upper half of the code means right half-frame
         if (frame_format == asm_pkg::FMT_TDM) begin
            eff_slot[i] = cfgs[i][asm_pkg::SLOT_MSB:0];
         end else begin
            eff_slot[i] = {1'b0, cfgs[i][asm_pkg::SLOT_MSB-1:0]};
         end
      end
      // in i2s/lj the half is picked by frame sync level: low is left
      assign hit[i] = (s_q.slot == eff_slot[i]) &&
                      ((frame_format == asm_pkg::FMT_TDM) ||
                       (cfgs[i][asm_pkg::SLOT_MSB] == fs_level));
      assign line_sel[i] = cfgs[i][asm_pkg::LINE_SEL_BIT];
   end

   assign f_ready = (s_q.load_idx != 2'd3);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic       pbit, sbit, pdrv, sdrv;
      logic [7:0] wv;
      pbit = 1'b0;
      sbit = 1'b0;
      pdrv = 1'b0;
      sdrv = 1'b0;
      wv   = reg_wdata & asm_pkg::CFG_WMASK;
      s_d  = s_q;
      s_d.bclk_sync = {s_q.bclk_sync[1:0], bit_clk_pin};
      s_d.fs_sync   = {s_q.fs_sync[1:0], frame_sync_pin};

      if (reg_wr && reg_page == asm_pkg::PAGE_ZERO) begin
         case (reg_addr)
            asm_pkg::CHAN_B_CFG_ADDR: s_d.cfg_b = wv;
            asm_pkg::CHAN_C_CFG_ADDR: s_d.cfg_c = wv;
            asm_pkg::CHAN_D_CFG_ADDR: s_d.cfg_d = wv;
            default: ;
         endcase
      end
      if (reg_rd) begin
         s_d.rdata = 8'h00;
         if (reg_page == asm_pkg::PAGE_ZERO) begin
            case (reg_addr)
               asm_pkg::CHAN_B_CFG_ADDR: s_d.rdata = s_q.cfg_b;
               asm_pkg::CHAN_C_CFG_ADDR: s_d.rdata = s_q.cfg_c;
               asm_pkg::CHAN_D_CFG_ADDR: s_d.rdata = s_q.cfg_d;
               default:                  s_d.rdata = 8'h00;
            endcase
         end
      end

      // sample words are staged b, c, d and latched into the send set at frame start
      if (f_valid && f_ready) begin
         case (s_q.load_idx)
            2'd0:    s_d.word_b = f_data;
            2'd1:    s_d.word_c = f_data;
            default: s_d.word_d = f_data;
         endcase
         s_d.load_idx = s_q.load_idx + 2'd1;
      end

      if (bclk_fall) begin
         for (int k = 0; k < 3; k++) begin
            if (hit[k]) begin
               if (line_sel[k]) begin
                  sbit = sbit | words[k][WORD_W-1-s_q.bitn];
                  sdrv = 1'b1;
               end else begin
                  pbit = pbit | words[k][WORD_W-1-s_q.bitn];
                  pdrv = 1'b1;
               end
            end
         end
         s_d.prim    = pbit;
         s_d.prim_oe = pdrv;
         s_d.sec     = sbit;
         s_d.sec_oe  = sdrv;
         if (s_q.bitn == 6'(WORD_W - 1)) begin
            s_d.bitn = '0;
            s_d.slot = s_q.slot + 6'd1;
         end else begin
            s_d.bitn = s_q.bitn + 6'd1;
         end
      end
      // a frame edge restarts slot 0; in two-channel formats each half restarts too
      if (fs_rise || (frame_format != asm_pkg::FMT_TDM &&
                      s_q.fs_sync[2] != s_q.fs_sync[1])) begin
         s_d.slot = '0;
         s_d.bitn = '0;
         if (fs_rise && s_q.load_idx == 2'd3) begin
            s_d.load_idx = 2'd0;
            s_d.out_b    = s_q.word_b;
            s_d.out_c    = s_q.word_c;
            s_d.out_d    = s_q.word_d;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q       <= '0;
         s_q.cfg_b <= asm_pkg::CHAN_B_RESET;
         s_q.cfg_c <= asm_pkg::CHAN_C_RESET;
         s_q.cfg_d <= asm_pkg::CHAN_D_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata          = s_q.rdata;
   assign primary_serial_out = s_q.prim;
   assign primary_serial_oe  = s_q.prim_oe;
   assign general_pin_one    = s_q.sec;
   assign general_pin_one_oe = s_q.sec_oe;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
      !s_q.cfg_b[7] && !s_q.cfg_c[7] && !s_q.cfg_d[7])
      else $error("reserved bit set");
   a_write_chan_b: assert property (@(posedge clk) disable iff (!reset_n)
      (reg_wr && reg_page == 8'h00 && reg_addr == 8'h0c) |=>
      s_q.cfg_b == ($past(reg_wdata) & 8'h7f))
      else $error("channel b write lost");
   a_read_back_c: assert property (@(posedge clk) disable iff (!reset_n)
      (reg_rd && !reg_wr && reg_page == 8'h00 && reg_addr == 8'h0d) |=>
      reg_rdata == $past(s_q.cfg_c))
      else $error("channel c readback wrong");
   a_primary_route: assert property (@(posedge clk) disable iff (!reset_n)
      (bclk_fall && |hit && !(|(hit & line_sel))) |=> primary_serial_oe && !general_pin_one_oe)
      else $error("primary line not driven");
   a_secondary_route: assert property (@(posedge clk) disable iff (!reset_n)
      (bclk_fall && |hit && !(|(hit & ~line_sel))) |=> general_pin_one_oe && !primary_serial_oe)
      else $error("secondary line not driven");
   a_tdm_slot_match: assert property (@(posedge clk) disable iff (!reset_n)
      (frame_format == 2'h0 && s_q.slot == s_q.cfg_b[5:0]) |-> hit[0])
      else $error("tdm slot not matched");
   a_right_half_slot: assert property (@(posedge clk) disable iff (!reset_n)
      (frame_format != 2'h0 && s_q.cfg_b[5] && !fs_level) |-> !hit[0])
      else $error("right half slot used in left half");
   a_idle_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
      (bclk_fall && hit == 3'b000) |=> !primary_serial_oe && !general_pin_one_oe)
      else $error("line driven in unassigned slot");
   a_reset_values: assert property (@(posedge clk)
      $rose(reset_n) |-> s_q.cfg_b == 8'h01 && s_q.cfg_c == 8'h02 && s_q.cfg_d == 8'h03)
      else $error("reset values wrong");
endmodule

// ==== asm_host_model.sv ====
// host-side receiver model: makes bit clock and frame sync, records both lines.
// assumes the device changes data after a bit clock fall, settled by the next rise.
`timescale 1ns/10ps
module asm_host_model (
   // clock
   input  wire logic clk,
   // device lines
   input  wire logic primary_serial_out,
   input  wire logic primary_serial_oe,
   input  wire logic general_pin_one,
   input  wire logic general_pin_one_oe,
   // framing
   output logic      bit_clk_pin,
   output logic      frame_sync_pin
);
   // ------------------------------------------------------------
   // frame capture, {oe, data} per bit of the frame
   // ------------------------------------------------------------
   logic [1:0] cap [2][2048];
   initial begin
      bit_clk_pin = 1'b1;
      frame_sync_pin = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bit clock stands high between frames; sync changes only mid high phase,
   // far from the falls, so the device never sees both move together
   task automatic run_frame(input int halves, input int half_bits);
      int k;
      k = 0;
      for (int h = 0; h < halves; h++) begin
         wait_clk(4);
         frame_sync_pin = (h == 0);
         wait_clk(4);
         for (int i = 0; i < half_bits; i++) begin
            bit_clk_pin = 1'b0;
            wait_clk(8);
            bit_clk_pin = 1'b1;
            cap[0][k] = {primary_serial_oe, primary_serial_out};
            cap[1][k] = {general_pin_one_oe, general_pin_one};
            k++;
            wait_clk(8);
         end
      end
      frame_sync_pin = 1'b0;
   endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the slot mapper: registers, sample fifo, slot placement.
// assumes the host model drives framing and records both serial lines.
`timescale 1ns/10ps
module testbench;
   logic        clk, reset_n, reg_wr, reg_rd, smp_valid, smp_ready;
   logic        bclk, fs, p_out, p_oe, g_out, g_oe;
   logic [1:0]  frame_format;
   logic [7:0]  reg_page, reg_addr, reg_wdata, reg_rdata, rv, e;
   logic [31:0] smp_data;
   logic [7:0]  cfg [3];
   logic [31:0] w [3];
   logic [31:0] q [$];
   int          seed = 20;
   int          mismatches = 0;
   int          checks = 0;
   int          fmt;
   asm_slot_mapper u_asm_slot_mapper (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .frame_format(frame_format), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_data(smp_data), .bit_clk_pin(bclk), .frame_sync_pin(fs),
      .primary_serial_out(p_out), .primary_serial_oe(p_oe), .general_pin_one(g_out),
      .general_pin_one_oe(g_oe));
   asm_host_model u_asm_host_model (.clk(clk), .primary_serial_out(p_out),
      .primary_serial_oe(p_oe), .general_pin_one(g_out), .general_pin_one_oe(g_oe),
      .bit_clk_pin(bclk), .frame_sync_pin(fs));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic summarize();
      if (mismatches == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // every access starts with an edge so strobes never toggle twice in one step
   task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
      step();
      {reg_page, reg_addr, reg_wdata, reg_wr} = {pg, a, d, 1'b1};
      step();
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] pg, input logic [7:0] a, output logic [7:0] d);
      step();
      {reg_page, reg_addr, reg_rd} = {pg, a, 1'b1};
      step();
      reg_rd = 1'b0;
      step();
      d = reg_rdata;
   endtask
   task automatic cset(input int c, input logic [7:0] d);
      wr(8'h00, 8'h0c + 8'(c), d);
      cfg[c] = d & asm_pkg::CFG_WMASK;
   endtask
   task automatic push(input logic [31:0] d);
      step();
      {smp_data, smp_valid} = {d, 1'b1};
      for (int i = 0; i < 40 && smp_ready !== 1'b1; i++) step();
      step();
      smp_valid = 1'b0;
      q.push_back(d);
   endtask
   task automatic feed();
      for (int c = 0; c < 3; c++) push($random(seed));
   endtask
   function automatic logic [1:0] exp_bit(input int l, input int s, input int p);
      logic [1:0] r;
      r = 2'b00;
      for (int c = 0; c < 3; c++)
         if (cfg[c][5:0] == 6'(s) && cfg[c][6] == l[0]) r = {1'b1, r[0] | w[c][31 - p]};
      return r;
   endfunction
   // tdm: one span of hb bits; other formats: right half after the rise, then left
   task automatic frame(input int f, input int hb);
      logic [1:0] x, g;
      int s;
      frame_format = 2'(f);
      for (int c = 0; c < 3; c++) w[c] = q.pop_front();
      u_asm_host_model.run_frame(f == 0 ? 1 : 2, hb);
      for (int k = 0; k < (f == 0 ? hb : 2 * hb); k++)
         for (int l = 0; l < 2; l++) begin
            s = (f == 0) ? k / 32 : (k < hb ? 32 : 0) + (k % hb) / 32;
            x = exp_bit(l, s, k % 32);
            g = u_asm_host_model.cap[l][k];
            checks++;
            if (g[1] !== x[1] || (x[1] && g[0] !== x[0])) begin
               mismatches++;
               $display("mismatch %0t line %0d bit %0d got %b exp %b", $time, l, k, g, x);
            end
         end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {reset_n, reg_wr, reg_rd, smp_valid, frame_format, reg_page, reg_addr} = '0;
      {reg_wdata, smp_data} = '0;
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      for (int c = 0; c < 3; c++) begin
         rd(8'h00, 8'h0c + 8'(c), rv);
         cmp(rv, 8'h01 + 8'(c));
         cfg[c] = 8'h01 + 8'(c);
      end
      feed();
      frame(0, 128);
      rd(8'h00, 8'h0b, rv);
      cmp(rv, 8'h00);
      wr(8'h01, 8'h0c, 8'h55);
      rd(8'h01, 8'h0c, rv);
      cmp(rv, 8'h00);
      rd(8'h00, 8'h0c, rv);
      cmp(rv, 8'h01);
      for (int i = 0; i < 8; i++) begin
         fmt = i % 4;
         for (int c = 0; c < 3; c++) begin
            e = 8'($random(seed)) & (fmt == 0 ? 8'hc7 : 8'he3);
            cset(c, e);
            rd(8'h00, 8'h0c + 8'(c), rv);
            cmp(rv, e & 8'h7f);
         end
         feed();
         frame(fmt, fmt == 0 ? 256 : 128);
      end
      // top slot on the secondary line, with the reserved bit written high
      cset(0, 8'hff);
      cset(1, 8'h20);
      cset(2, 8'h00);
      feed();
      frame(0, 2048);
      cset(0, 8'h41);
      cset(1, 8'h03);
      step();
      {smp_data, smp_valid} = {32'($random(seed)), 1'b1};
      for (int i = 0; i < 20; i++) begin
         if (smp_ready !== 1'b1) break;
         q.push_back(smp_data);
         step();
         smp_data = $random(seed);
      end
      step();
      smp_valid = 1'b0;
      // capacity: fifo depth, the fifo's output register and three staged words
      cmp(8'(q.size()), 8'(asm_pkg::FIFO_DEPTH + 4));
      repeat (3) frame(0, 128);
      cmp({7'h00, smp_ready}, 8'h01);
      summarize();
   end
   initial begin
      #950000;
      mismatches++;
      summarize();
   end
endmodule
